// File: hdl/xcvr_flags_pkg.sv
// Constants and types for the transceiver status and error flags
package xcvr_flags_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS     = 20;
  localparam int T_TRANSMIT_ENABLE_N_IN_CLAMP_NS   = 40000;
  localparam int T_GUARD_CLAMP_NS  = 40000;
  localparam int T_CORE_UV_DET_NS  = 2000;
  localparam int T_CORE_UV_REC_NS  = 2000;
  localparam int T_IO_UV_DET_NS    = 2000;
  localparam int T_IO_UV_REC_NS    = 2000;

  // Least times round up to whole cycles, never below one
  function automatic logic [15:0] cyc_min(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    if (c < 1) begin
      c = 1;
    end
    return c[15:0];
  endfunction : cyc_min

  // ----------------------------------------------------------------
  // Hold timers
  // ----------------------------------------------------------------
  localparam int HOLD_N         = 6;
  localparam int HOLD_TRANSMIT_ENABLE_N_IN      = 0;
  localparam int HOLD_GUARD     = 1;
  localparam int HOLD_CORE_DET  = 2;
  localparam int HOLD_CORE_REC  = 3;
  localparam int HOLD_IO_DET    = 4;
  localparam int HOLD_IO_REC    = 5;

  function automatic logic [15:0] hold_limit(input int idx);
    case (idx)
      HOLD_TRANSMIT_ENABLE_N_IN:     return cyc_min(T_TRANSMIT_ENABLE_N_IN_CLAMP_NS);
      HOLD_GUARD:    return cyc_min(T_GUARD_CLAMP_NS);
      HOLD_CORE_DET: return cyc_min(T_CORE_UV_DET_NS);
      HOLD_CORE_REC: return cyc_min(T_CORE_UV_REC_NS);
      HOLD_IO_DET:   return cyc_min(T_IO_UV_DET_NS);
      default:       return cyc_min(T_IO_UV_REC_NS);
    endcase
  endfunction : hold_limit

  // ----------------------------------------------------------------
  // Serial readout
  // ----------------------------------------------------------------
  localparam logic [4:0] READOUT_EDGES = 5'h10;
  localparam logic [4:0] EDGE_CNT_MAX  = 5'h11;

  // ----------------------------------------------------------------
  // Flags, high bit first as shown in the status word
  // ----------------------------------------------------------------
  typedef struct packed {
    logic readout_err;
    logic io_supply_uv;
    logic core_supply_uv;
    logic transmit_enable_n_in_clamped;
    logic over_temp;
    logic bus_error;
    logic power_on;
    logic guard_clamped;
    logic tx_on;
    logic normal;
    logic bus_wake;
  } flags_t;

  localparam logic [10:0] FLAGS_RST    = 11'h010;
  localparam logic [10:0] ERR_MASK     = 11'h7e0;
  localparam logic [10:0] LATCH_MASK   = 11'h7f0;

  // Synchronised pin order
  localparam int PIN_N      = 5;
  localparam int PIN_TRANSMIT_ENABLE_N_IN_N = 0;
  localparam int PIN_STBY_N = 1;
  localparam int PIN_GUARD  = 2;
  localparam int PIN_SEL_N  = 3;
  localparam int PIN_SCLK   = 4;

endpackage : xcvr_flags_pkg

// File: hdl/hold_timer.sv
// Counts how long a condition has held and flags when it reaches a limit
`timescale 1ns/1ps
module hold_timer #(
  parameter logic [15:0] LIMIT = 16'h0001
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // Condition and result
  input  wire logic cond,
  output logic      expired
);

  logic [15:0] count_reg;
  logic [15:0] count_next;
  logic        expired_reg;
  logic        expired_next;

  always_comb begin
    count_next = 16'h0000;
    if (cond) begin
      count_next = (count_reg == LIMIT) ? count_reg : count_reg + 16'h0001;
    end
    expired_next = cond && (count_next == LIMIT);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count_reg   <= 16'h0000;
      expired_reg <= 1'b0;
    end else begin
      count_reg   <= count_next;
      expired_reg <= expired_next;
    end
  end

  assign expired = expired_reg;

endmodule : hold_timer

// File: hdl/xcvr_flags.sv
// Status and error flag logic of the bus node transceiver
//
// What this block does
// - Keep eleven status and error flags
// - Wake flag: bus wake in standby, clears entering normal
// - Wake flag forces receive low, error low if standby
// - Normal flag follows normal operation
// - Transmitter on only when guardian, normal, no overtemperature or transmit-enable clamp
// - Guardian clamp: high too long, clears when low
// - Power-on flag set at init, clears entering normal
// - Bus error: set on fault, clear otherwise
// - Overtemperature disables transmitter, error low
// - Transmit-enable low too long disables transmitter
// - Supply undervoltage flags force standby, error low
// - Readout error floats data, cleared by select fall
// - Readout error unless exactly sixteen clock falls
// - Reset clears all flags but sets power-on
// - Four fault flags change only in normal
// - Readout mode latches status until complete readout
// - Readout mode: error low while error bits set
`timescale 1ns/1ps
module xcvr_flags (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rstn,
  // Host pins, asynchronous
  input  wire logic                  transmit_enable_n_in,
  input  wire logic                  standby_ctrl_n,
  input  wire logic                  guardian_enable_in,
  input  wire logic                  readout_select_n,
  input  wire logic                  readout_clk_in,
  // Internal monitors and mode, on clk
  input  wire logic                  bus_wake_event,
  input  wire logic                  bus_fault,
  input  wire logic                  temp_high,
  input  wire logic                  core_supply_low,
  input  wire logic                  io_supply_low,
  input  wire logic                  readout_mode,
  // Pin and transmitter controls
  output logic                       error_indicator_n,
  output logic                       rx_force_low,
  output logic                       tx_enable,
  output logic                       readout_data_float,
  // Flag and status state
  output xcvr_flags_pkg::flags_t     flags,
  output xcvr_flags_pkg::flags_t     status_bits
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [xcvr_flags_pkg::PIN_N-1:0] pin_meta_reg;
  logic [xcvr_flags_pkg::PIN_N-1:0] pin_sync_reg;
  logic [xcvr_flags_pkg::PIN_N-1:0] pin_prev_reg;
  logic [xcvr_flags_pkg::PIN_N-1:0] pin_raw;

  assign pin_raw = {readout_clk_in, readout_select_n, guardian_enable_in,
                    standby_ctrl_n, transmit_enable_n_in};

  // Idle levels keep reset from looking like edges; standby level on
  // the mode pin, so reset alone never enters normal and drops power-on
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pin_meta_reg <= 5'h19;
      pin_sync_reg <= 5'h19;
      pin_prev_reg <= 5'h19;
    end else begin
      pin_meta_reg <= pin_raw;
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg;
    end
  end

  logic transmit_enable_n_in_hi;
  logic transmit_enable_n_in_rise;
  logic stby_hi;
  logic guard_hi;
  logic sel_hi;
  logic sel_fall;
  logic sel_rise;
  logic sclk_fall;

  assign transmit_enable_n_in_hi   = pin_sync_reg[xcvr_flags_pkg::PIN_TRANSMIT_ENABLE_N_IN_N];
  assign transmit_enable_n_in_rise = transmit_enable_n_in_hi & ~pin_prev_reg[xcvr_flags_pkg::PIN_TRANSMIT_ENABLE_N_IN_N];
  assign stby_hi   = pin_sync_reg[xcvr_flags_pkg::PIN_STBY_N];
  assign guard_hi  = pin_sync_reg[xcvr_flags_pkg::PIN_GUARD];
  assign sel_hi    = pin_sync_reg[xcvr_flags_pkg::PIN_SEL_N];
  assign sel_fall  = ~sel_hi & pin_prev_reg[xcvr_flags_pkg::PIN_SEL_N];
  assign sel_rise  = sel_hi & ~pin_prev_reg[xcvr_flags_pkg::PIN_SEL_N];
  assign sclk_fall = ~pin_sync_reg[xcvr_flags_pkg::PIN_SCLK]
                   & pin_prev_reg[xcvr_flags_pkg::PIN_SCLK];

  // ----------------------------------------------------------------
  // Hold timers
  // ----------------------------------------------------------------
  xcvr_flags_pkg::flags_t flags_reg;
  xcvr_flags_pkg::flags_t flags_next;
  logic [xcvr_flags_pkg::HOLD_N-1:0] hold_cond;
  logic [xcvr_flags_pkg::HOLD_N-1:0] hold_done;

  // Clamp timers only run in normal operation
  assign hold_cond[xcvr_flags_pkg::HOLD_TRANSMIT_ENABLE_N_IN]     = flags_reg.normal & ~transmit_enable_n_in_hi;
  assign hold_cond[xcvr_flags_pkg::HOLD_GUARD]    = flags_reg.normal & guard_hi;
  assign hold_cond[xcvr_flags_pkg::HOLD_CORE_DET] = core_supply_low;
  assign hold_cond[xcvr_flags_pkg::HOLD_CORE_REC] = ~core_supply_low;
  assign hold_cond[xcvr_flags_pkg::HOLD_IO_DET]   = io_supply_low;
  assign hold_cond[xcvr_flags_pkg::HOLD_IO_REC]   = ~io_supply_low;

  generate
    for (genvar i = 0; i < xcvr_flags_pkg::HOLD_N; i++) begin : g_hold
      hold_timer #(
        .LIMIT (xcvr_flags_pkg::hold_limit(i))
      ) u_hold (
        .clk     (clk),
        .rstn    (rstn),
        .cond    (hold_cond[i]),
        .expired (hold_done[i])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Readout clock edge counter
  // ----------------------------------------------------------------
  logic [4:0] edge_cnt_reg;
  logic [4:0] edge_cnt_next;
  logic       readout_ok;
  logic       readout_bad;

  always_comb begin
    edge_cnt_next = edge_cnt_reg;
    if (sel_fall) begin
      edge_cnt_next = 5'h00;
    end else if (!sel_hi && sclk_fall
                 && edge_cnt_reg != xcvr_flags_pkg::EDGE_CNT_MAX) begin
      edge_cnt_next = edge_cnt_reg + 5'h01;
    end
  end

  // Too many shows at once; too few only when select returns high.
  // A stale count at the next select fall must not set the flag again
  assign readout_ok  = sel_rise
                     && edge_cnt_reg == xcvr_flags_pkg::READOUT_EDGES;
  assign readout_bad = readout_mode
                     && ((!sel_hi && !sel_fall
                          && edge_cnt_reg > xcvr_flags_pkg::READOUT_EDGES)
                         || (sel_rise
                          && edge_cnt_reg < xcvr_flags_pkg::READOUT_EDGES));

  // ----------------------------------------------------------------
  // Flag next state
  // ----------------------------------------------------------------
  logic enter_normal;
  logic gate_fault;

  always_comb begin
    flags_next = flags_reg;
    // Undervoltage flags, set wins over recovery
    if (hold_done[xcvr_flags_pkg::HOLD_CORE_DET]) begin
      flags_next.core_supply_uv = 1'b1;
    end else if (hold_done[xcvr_flags_pkg::HOLD_CORE_REC]) begin
      flags_next.core_supply_uv = 1'b0;
    end
    if (hold_done[xcvr_flags_pkg::HOLD_IO_DET]) begin
      flags_next.io_supply_uv = 1'b1;
    end else if (hold_done[xcvr_flags_pkg::HOLD_IO_REC]) begin
      flags_next.io_supply_uv = 1'b0;
    end
    // Undervoltage forces standby
    flags_next.normal = stby_hi & ~flags_reg.core_supply_uv
                      & ~flags_reg.io_supply_uv;
    enter_normal = flags_next.normal & ~flags_reg.normal;
    // Sampled while normal, so the leaving cycle still updates
    gate_fault   = flags_reg.normal;
    if (bus_wake_event && !flags_reg.normal
        && !flags_reg.core_supply_uv) begin
      flags_next.bus_wake = 1'b1;
    end else if (enter_normal) begin
      flags_next.bus_wake = 1'b0;
    end
    if (enter_normal) begin
      flags_next.power_on = 1'b0;
    end
    flags_next.tx_on = guard_hi & flags_reg.normal & ~flags_reg.over_temp
                     & ~flags_reg.transmit_enable_n_in_clamped;
    if (gate_fault) begin
      if (hold_done[xcvr_flags_pkg::HOLD_GUARD]) begin
        flags_next.guard_clamped = 1'b1;
      end else if (!guard_hi) begin
        flags_next.guard_clamped = 1'b0;
      end
      // Fault wins over a clearing edge in the same cycle
      if (bus_fault) begin
        flags_next.bus_error = 1'b1;
      end else if (!bus_fault || transmit_enable_n_in_rise) begin
        flags_next.bus_error = 1'b0;
      end
      if (temp_high) begin
        flags_next.over_temp = 1'b1;
      end else if (transmit_enable_n_in_hi) begin
        flags_next.over_temp = 1'b0;
      end
      if (hold_done[xcvr_flags_pkg::HOLD_TRANSMIT_ENABLE_N_IN]) begin
        flags_next.transmit_enable_n_in_clamped = 1'b1;
      end else if (transmit_enable_n_in_hi) begin
        flags_next.transmit_enable_n_in_clamped = 1'b0;
      end
    end
    if (readout_bad) begin
      flags_next.readout_err = 1'b1;
    end else if (sel_fall) begin
      flags_next.readout_err = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Status latch and pin controls
  // ----------------------------------------------------------------
  xcvr_flags_pkg::flags_t status_reg;
  xcvr_flags_pkg::flags_t status_next;
  logic                   err_n_reg;
  logic                   err_n_next;
  logic                   float_reg;
  logic                   float_next;
  logic                   any_err;

  always_comb begin
    // Latched bits hold until a complete readout, then follow the flag
    if (readout_mode) begin
      status_next = (flags_reg & xcvr_flags_pkg::LATCH_MASK)
                  | (status_reg & xcvr_flags_pkg::LATCH_MASK
                     & {11{~readout_ok}})
                  | (flags_reg & ~xcvr_flags_pkg::LATCH_MASK);
    end else begin
      status_next = flags_reg;
    end
    any_err = readout_mode
            ? |(status_reg & xcvr_flags_pkg::ERR_MASK)
            : |(flags_reg & xcvr_flags_pkg::ERR_MASK & 11'h3ff);
    err_n_next = ~((flags_reg.bus_wake && !stby_hi)
                   || (stby_hi && any_err));
    float_next = sel_hi || !readout_mode || flags_reg.readout_err;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      flags_reg  <= xcvr_flags_pkg::FLAGS_RST;
      status_reg <= xcvr_flags_pkg::FLAGS_RST;
      edge_cnt_reg <= 5'h00;
      err_n_reg  <= 1'b1;
      float_reg  <= 1'b1;
    end else begin
      flags_reg  <= flags_next;
      status_reg <= status_next;
      edge_cnt_reg <= edge_cnt_next;
      err_n_reg  <= err_n_next;
      float_reg  <= float_next;
    end
  end

  assign error_indicator_n  = err_n_reg;
  assign rx_force_low       = flags_reg.bus_wake;
  assign tx_enable          = flags_reg.tx_on;
  assign readout_data_float = float_reg;
  assign flags              = flags_reg;
  assign status_bits        = status_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_tx_needs_clean: assert property (@(posedge clk) disable iff (!rstn)
    tx_enable |-> $past(guard_hi) && !$past(flags_reg.over_temp)
                  && !$past(flags_reg.transmit_enable_n_in_clamped))
    else $error("transmitter enabled while blocked");
  chk_wake_clear_normal: assert property (@(posedge clk) disable iff (!rstn)
    $rose(flags_reg.normal) && !$past(bus_wake_event) |-> !flags_reg.bus_wake)
    else $error("wake flag survived entry to normal");
  chk_power_on_flag_clear: assert property (@(posedge clk) disable iff (!rstn)
    $rose(flags_reg.normal) |-> !flags_reg.power_on)
    else $error("power-on flag survived entry to normal");
  chk_fault_gate: assert property (@(posedge clk) disable iff (!rstn)
    !$past(flags_reg.normal) |-> $stable(flags_reg.over_temp)
                                 && $stable(flags_reg.bus_error))
    else $error("fault flag changed outside normal");
  chk_uv_standby: assert property (@(posedge clk) disable iff (!rstn)
    flags_reg.core_supply_uv |=> !flags_reg.normal)
    else $error("normal while core supply low");
  chk_sel_clears_err: assert property (@(posedge clk) disable iff (!rstn)
    sel_fall |=> !flags_reg.readout_err)
    else $error("readout error not cleared by select");
  chk_short_readout: assert property (@(posedge clk) disable iff (!rstn)
    readout_mode && sel_rise && edge_cnt_reg == 5'h0f |=> flags_reg.readout_err)
    else $error("fifteen edges not flagged");
  chk_wake_pins: assert property (@(posedge clk) disable iff (!rstn)
    flags_reg.bus_wake && !stby_hi |=> !error_indicator_n && rx_force_low)
    else $error("wake flag not shown on pins");
  chk_temp_blocks_tx: assert property (@(posedge clk) disable iff (!rstn)
    flags_reg.over_temp |=> !tx_enable)
    else $error("transmitter on during overtemperature");

endmodule : xcvr_flags

// File: verif/host_pins_model.sv
// Host side pin driver for the transceiver flag block
`timescale 1ns/1ps
module host_pins_model (
  // Clock
  input  wire logic clk,
  // Host pins
  output logic      transmit_enable_n_in,
  output logic      standby_ctrl_n,
  output logic      guardian_enable_in,
  output logic      readout_select_n,
  output logic      readout_clk_in
);
  initial begin
    transmit_enable_n_in = 1'b1;
    standby_ctrl_n       = 1'b0;
    guardian_enable_in   = 1'b0;
    readout_select_n     = 1'b1;
    readout_clk_in       = 1'b1;
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  task automatic pins(input logic transmit_enable_n_in_n, input logic stby_n,
                      input logic guard);
    step(1);
    transmit_enable_n_in = transmit_enable_n_in_n;
    standby_ctrl_n       = stby_n;
    guardian_enable_in   = guard;
  endtask : pins

  task automatic select(input logic v);
    step(1);
    readout_select_n = v;
  endtask : select

  // ----------------------------------------------------------------
  // Readout frame
  // ----------------------------------------------------------------
  // Serial clock idles high outside frames; half period of four cycles
  // so the two-stage synchroniser sees every edge
  task automatic readout(input int falls);
    step(1);
    readout_select_n = 1'b0;
    step(4);
    for (int i = 0; i < falls; i++) begin
      readout_clk_in = 1'b0;
      step(4);
      readout_clk_in = 1'b1;
      step(4);
    end
    readout_select_n = 1'b1;
    step(6);
  endtask : readout
endmodule : host_pins_model

// File: verif/xcvr_flags_tb.sv
// Self-checking bench for the transceiver flag block
`timescale 1ns/1ps
module xcvr_flags_tb;
  logic                   clk;
  logic                   rstn;
  logic                   bus_wake_event;
  logic                   bus_fault;
  logic                   temp_high;
  logic                   core_supply_low;
  logic                   io_supply_low;
  logic                   readout_mode;
  wire logic              transmit_enable_n_in_n;
  wire logic              stby_n;
  wire logic              guard;
  wire logic              sel_n;
  wire logic              sclk;
  logic                   error_indicator_n;
  logic                   rx_force_low;
  logic                   tx_enable;
  logic                   readout_data_float;
  xcvr_flags_pkg::flags_t flags;
  xcvr_flags_pkg::flags_t status_bits;
  logic [10:0]            fl;
  int                     bad_count;
  int                     checks_done;

  assign fl = flags;

  host_pins_model host_pins_model_inst (
    .clk                  (clk),
    .transmit_enable_n_in (transmit_enable_n_in_n),
    .standby_ctrl_n       (stby_n),
    .guardian_enable_in   (guard),
    .readout_select_n     (sel_n),
    .readout_clk_in       (sclk)
  );

  xcvr_flags xcvr_flags_inst (
    .clk                  (clk),
    .rstn                 (rstn),
    .transmit_enable_n_in (transmit_enable_n_in_n),
    .standby_ctrl_n       (stby_n),
    .guardian_enable_in   (guard),
    .readout_select_n     (sel_n),
    .readout_clk_in       (sclk),
    .bus_wake_event       (bus_wake_event),
    .bus_fault            (bus_fault),
    .temp_high            (temp_high),
    .core_supply_low      (core_supply_low),
    .io_supply_low        (io_supply_low),
    .readout_mode         (readout_mode),
    .error_indicator_n    (error_indicator_n),
    .rx_force_low         (rx_force_low),
    .tx_enable            (tx_enable),
    .readout_data_float   (readout_data_float),
    .flags                (flags),
    .status_bits          (status_bits)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : test_done

  task automatic check(input string what, input logic [10:0] exp,
                       input logic [10:0] got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // Pins: error_n, rx low, tx enable, float
  task automatic outs(input string what, input logic [3:0] exp);
    step(2);
    check(what, {7'h0, exp}, {7'h0, error_indicator_n, rx_force_low,
                              tx_enable, readout_data_float});
  endtask : outs

  // Bounded wait on one flag; running out ends the run
  task automatic wait_flag(input string what, input int idx,
                           input logic v, input int lim);
    int n;
    n = 0;
    while (fl[idx] !== v && n < lim) begin
      step(1);
      n++;
    end
    check(what, {10'h0, v}, {10'h0, fl[idx]});
    if (fl[idx] !== v) begin
      test_done();
    end
  endtask : wait_flag

  initial begin
    repeat (100000) @(posedge clk);
    bad_count++;
    $display("BAD watchdog expected end seen hang");
    test_done();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    rstn = 1'b0;
    bus_wake_event = 1'b0;
    bus_fault = 1'b0;
    temp_high = 1'b0;
    core_supply_low = 1'b0;
    io_supply_low = 1'b0;
    readout_mode = 1'b0;
    bad_count = 0;
    checks_done = 0;
    step(20);
    check("reset flags", 11'h010, flags);
    check("reset status", 11'h010, status_bits);
    outs("reset pins", 4'b1001);
    rstn = 1'b1;
    step(3);
    check("standby flags", 11'h010, flags);
    $display("test reset done");
    host_pins_model_inst.pins(1'b1, 1'b1, 1'b1);
    wait_flag("normal", 1, 1'b1, 20);
    outs("normal pins", 4'b1011);
    check("normal flags", 11'h006, flags);
    temp_high = 1'b1;
    wait_flag("over temp", 6, 1'b1, 10);
    outs("temp pins", 4'b0001);
    temp_high = 1'b0;
    wait_flag("temp clear", 6, 1'b0, 10);
    outs("temp clear pins", 4'b1011);
    bus_fault = 1'b1;
    wait_flag("bus error", 5, 1'b1, 10);
    outs("bus error pins", 4'b0011);
    bus_fault = 1'b0;
    wait_flag("bus error clear", 5, 1'b0, 10);
    $display("test faults done");
    // Guardian held high since entering normal, so its clamp is set too
    host_pins_model_inst.pins(1'b0, 1'b1, 1'b1);
    wait_flag("transmit_enable_n_in clamp", 7, 1'b1, 2100);
    outs("clamp pins", 4'b0001);
    check("clamp flags", 11'h08a, flags);
    host_pins_model_inst.pins(1'b1, 1'b1, 1'b0);
    wait_flag("transmit_enable_n_in unclamp", 7, 1'b0, 10);
    outs("unclamp pins", 4'b1001);
    check("unclamp flags", 11'h002, flags);
    host_pins_model_inst.pins(1'b1, 1'b0, 1'b1);
    step(5);
    bus_fault = 1'b1;
    step(5);
    check("standby fault", 11'h000, flags);
    bus_fault = 1'b0;
    bus_wake_event = 1'b1;
    step(1);
    bus_wake_event = 1'b0;
    wait_flag("wake", 0, 1'b1, 10);
    outs("wake pins", 4'b0101);
    host_pins_model_inst.pins(1'b1, 1'b1, 1'b1);
    wait_flag("wake clear", 0, 1'b0, 20);
    outs("rewake pins", 4'b1011);
    $display("test modes done");
    for (int i = 0; i < 2; i++) begin
      core_supply_low = (i == 0);
      io_supply_low = (i == 1);
      wait_flag("uv set", 8 + i, 1'b1, 200);
      outs("uv pins", 4'b0001);
      check("uv flags", 11'h100 << i, flags);
      core_supply_low = 1'b0;
      io_supply_low = 1'b0;
      wait_flag("uv clear", 8 + i, 1'b0, 200);
      wait_flag("uv normal", 1, 1'b1, 20);
    end
    $display("test supply done");
    readout_mode = 1'b1;
    step(2);
    host_pins_model_inst.readout(16);
    check("good readout", 11'h006, flags);
    host_pins_model_inst.select(1'b0);
    step(1);
    outs("frame pins", 4'b1010);
    host_pins_model_inst.select(1'b1);
    wait_flag("empty frame", 10, 1'b1, 10);
    outs("empty frame pins", 4'b0011);
    host_pins_model_inst.readout(15);
    check("short readout", 11'h406, flags);
    outs("readout err pins", 4'b0011);
    host_pins_model_inst.readout(17);
    check("long readout", 11'h406, flags);
    host_pins_model_inst.readout(16);
    check("readout clear", 11'h006, flags);
    outs("readout ok pins", 4'b1011);
    bus_fault = 1'b1;
    step(3);
    bus_fault = 1'b0;
    wait_flag("latch src", 5, 1'b0, 10);
    step(2);
    check("latched status", 11'h026, status_bits);
    outs("latched pins", 4'b0011);
    host_pins_model_inst.readout(16);
    check("refreshed status", 11'h006, status_bits);
    outs("refreshed pins", 4'b1011);
    $display("test readout done");
    test_done();
  end
endmodule : xcvr_flags_tb
